// ### rtl/cfd_config_decode.v
// Configuration loader: latches fuse word, decodes clock/watchdog, serves table reads
`timescale 1ns/100ps

// Notes on behaviour
// - Oscillator field: off, fast, standard, driven
// - Policy 11: watchdog always on, RC on
// - Policy 10: software bit gates watchdog, RC
// - Policy 01: runs when active, stops sleeping
// - Policy 00: watchdog never runs
// - Window-off bit 1 non-window, 0 window
// - Lock bit enables PLL lock
// - Prescaler divides by 128 or 32
// - Postscaler 1111 is 32768, 1110 16384
// - Trim words at fixed configuration addresses
// - Part identifier and revision words readable
module cfd_config_decode
#(
    parameter [15:0] PART_ID_VALUE  = 16'h0A5A,  // Arbitrary identification value
    parameter [15:0] SILICON_REV    = 16'h0001   // Arbitrary revision value
)
(
    // Clock and reset
    input  wire        mclk,
    input  wire        rst,
    // Nonvolatile configuration contents, stable while load_strobe pulses
    input  wire        load_strobe,
    input  wire [10:0] cfg_word,
    input  wire [4:0]  pga1_trim_nv,
    input  wire [4:0]  pga2_trim_nv,
    input  wire [5:0]  isrc_trim_nv,
    // Software and power state
    input  wire        soft_watchdog_on_bit,
    input  wire        sleep_mode,
    // Table read port into configuration space
    input  wire        tbl_rd,
    input  wire [7:0]  table_page_pointer,
    input  wire [15:0] tbl_offset,
    output reg  [23:0] tbl_data,
    output reg         tbl_valid,
    // Decoded oscillator controls
    output wire        posc_enable,
    output wire        fast_crystal_mode,
    output wire        standard_crystal_mode,
    output wire        driven_clock_input_mode,
    output reg         pll_lock_enable,
    // Decoded watchdog controls
    output wire        wdt_run,
    output wire        low_power_rc_osc,
    output reg         wdt_window_mode,
    output reg  [7:0]  wdt_pre_ratio,
    output reg  [15:0] wdt_post_ratio,
    output wire        wdt_prescale_tick,
    output wire        wdt_timeout
);
`include "cfd_map.vh"

    localparam ST_RESET  = 2'b01;
    localparam ST_LOADED = 2'b10;

    reg [1:0]  state;
    reg [10:0] cfg;
    reg [4:0]  pga1_trim;
    reg [4:0]  pga2_trim;
    reg [5:0]  isrc_trim;
    reg [7:0]  pre_cnt;
    reg [15:0] post_cnt;
    reg        pre_tick;
    reg        post_hit;
    reg [23:0] next_tbl_data;

    wire [1:0] primary_osc_mode_field  = cfg[`CFD_POSC_LSB +: 2];
    wire [1:0] watchdog_policy_field   = cfg[`CFD_WDTPOL_LSB +: 2];
    wire       watchdog_window_off_bit = cfg[`CFD_WINOFF_BIT];
    wire       pll_lock_on_bit         = cfg[`CFD_PLLLOCK_BIT];
    wire       watchdog_prediv_bit     = cfg[`CFD_PREDIV_BIT];
    wire [3:0] watchdog_postdiv_field  = cfg[`CFD_POSTDIV_LSB +: 4];
    wire [23:0] tbl_addr               = {table_page_pointer, tbl_offset};
    wire        loaded                 = state[1];

    // Ratio is 2^code; code 1111 gives 32768, 1110 gives 16384
    function [15:0] post_ratio;
        input [3:0] code;
        begin
            post_ratio = 16'h0001 << code;
        end
    endfunction

    cfd_osc_decode u_osc
    (
        .primary_osc_mode_field  (primary_osc_mode_field),
        .posc_enable             (posc_enable),
        .fast_crystal_mode       (fast_crystal_mode),
        .standard_crystal_mode   (standard_crystal_mode),
        .driven_clock_input_mode (driven_clock_input_mode)
    );

    cfd_wdt_policy u_wdt
    (
        .watchdog_policy_field (watchdog_policy_field),
        .soft_watchdog_on_bit  (soft_watchdog_on_bit),
        .sleep_mode            (sleep_mode),
        .wdt_run               (wdt_run),
        .low_power_rc_osc_keep_on          (low_power_rc_osc)
    );

    // Hold the erased (all ones) pattern until loaded, so wdt_run and the RC oscillator
    // stay on (the divider does not count until loaded) and the primary oscillator off until fuses are known.
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            state     <= ST_RESET;
            cfg       <= 11'h7FF;
            pga1_trim <= 5'h00;
            pga2_trim <= 5'h00;
            isrc_trim <= 6'h00;
        end
        else
        begin
            case (state)
                ST_RESET:
                begin
                    if (load_strobe)
                    begin
                        cfg       <= cfg_word;
                        pga1_trim <= pga1_trim_nv;
                        pga2_trim <= pga2_trim_nv;
                        isrc_trim <= isrc_trim_nv;
                        state     <= ST_LOADED;
                    end
                end
                ST_LOADED:
                    state <= ST_LOADED;
                default:
                    state <= ST_RESET;
            endcase
        end
    end

    // Registered decode of the single-bit and ratio fields
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            wdt_window_mode <= 1'b0;
            pll_lock_enable <= 1'b1;
            wdt_pre_ratio   <= `CFD_PRE_LARGE;
            wdt_post_ratio  <= 16'h8000;
        end
        else
        begin
            wdt_window_mode <= ~watchdog_window_off_bit;
            pll_lock_enable <= pll_lock_on_bit;
            wdt_pre_ratio   <= watchdog_prediv_bit ? `CFD_PRE_LARGE : `CFD_PRE_SMALL;
            wdt_post_ratio  <= post_ratio(watchdog_postdiv_field);
        end
    end

    // Divider chain: prescaler enable pulse feeds the postscaler.
    // Counts are reset when the watchdog stops, as a stopped timer restarts fresh.
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            pre_cnt  <= 8'h00;
            post_cnt <= 16'h0000;
            pre_tick <= 1'b0;
            post_hit <= 1'b0;
        end
        else if (!wdt_run || !loaded)
        begin
            pre_cnt  <= 8'h00;
            post_cnt <= 16'h0000;
            pre_tick <= 1'b0;
            post_hit <= 1'b0;
        end
        else
        begin
            pre_tick <= 1'b0;
            post_hit <= 1'b0;
            if (pre_cnt == wdt_pre_ratio - 8'h01)
            begin
                pre_cnt  <= 8'h00;
                pre_tick <= 1'b1;
                if (post_cnt == wdt_post_ratio - 16'h0001)
                begin
                    post_cnt <= 16'h0000;
                    post_hit <= 1'b1;
                end
                else
                    post_cnt <= post_cnt + 16'h0001;
            end
            else
                pre_cnt <= pre_cnt + 8'h01;
        end
    end

    assign wdt_prescale_tick = pre_tick;
    assign wdt_timeout       = post_hit;

    // Table read decode; trims sit in low bits, upper bits read zero
    always @*
    begin
        case (tbl_addr)
            `CFD_ADDR_GAIN_AMP1_TRIM:   next_tbl_data = {19'h0_0000, pga1_trim};
            `CFD_ADDR_GAIN_AMP2_TRIM:   next_tbl_data = {19'h0_0000, pga2_trim};
            `CFD_ADDR_CURRENT_SRC_TRIM: next_tbl_data = {18'h0_0000, isrc_trim};
            `CFD_ADDR_PART_ID:          next_tbl_data = {8'h00, PART_ID_VALUE};
            `CFD_ADDR_SILICON_REV:      next_tbl_data = {8'h00, SILICON_REV};
            default:                    next_tbl_data = 24'h00_0000;
        endcase
    end

    // Firmware relies on these reads to copy trims before enabling modules
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            tbl_data  <= 24'h00_0000;
            tbl_valid <= 1'b0;
        end
        else
        begin
            tbl_valid <= tbl_rd;
            if (tbl_rd)
                tbl_data <= next_tbl_data;
        end
    end
endmodule

// ### rtl/cfd_map.vh
// Configuration word layout, calibration addresses and decode constants
`ifndef CFD_MAP_VH
`define CFD_MAP_VH

// Configuration space addresses (24-bit)
`define CFD_ADDR_GAIN_AMP1_TRIM     24'h80_0E48
`define CFD_ADDR_GAIN_AMP2_TRIM     24'h80_0E4C
`define CFD_ADDR_CURRENT_SRC_TRIM   24'h80_0E78
`define CFD_ADDR_PART_ID            24'hFF_0000
`define CFD_ADDR_SILICON_REV        24'hFF_0002

// Loaded configuration word field positions
`define CFD_POSC_LSB       0
`define CFD_WDTPOL_LSB     2
`define CFD_WINOFF_BIT     4
`define CFD_PLLLOCK_BIT    5
`define CFD_PREDIV_BIT     6
`define CFD_POSTDIV_LSB    7
`define CFD_CFG_WIDTH      11

// Trim field widths inside 24-bit words
`define CFD_PGA_TRIM_W     5
`define CFD_ISRC_TRIM_W    6

// Primary oscillator mode codes
`define CFD_POSC_OFF       2'h3
`define CFD_POSC_FAST      2'h2
`define CFD_POSC_STD       2'h1
`define CFD_POSC_DRIVEN    2'h0

// Watchdog policy codes
`define CFD_WDT_ALWAYS     2'h3
`define CFD_WDT_SOFT       2'h2
`define CFD_WDT_ACTIVE     2'h1
`define CFD_WDT_NEVER      2'h0

// Prescale ratios
`define CFD_PRE_LARGE      8'h80
`define CFD_PRE_SMALL      8'h20

`endif

// ### rtl/cfd_wdt_policy.v
// Watchdog run and low-power oscillator policy decode
`timescale 1ns/100ps
module cfd_wdt_policy
(
    // Configuration and software control
    input  wire [1:0] watchdog_policy_field,
    input  wire       soft_watchdog_on_bit,
    input  wire       sleep_mode,
    // Decoded controls
    output reg        wdt_run,
    output reg        low_power_rc_osc_keep_on
);
`include "cfd_map.vh"

    always @*
    begin
        case (watchdog_policy_field)
            `CFD_WDT_ALWAYS:
            begin
                wdt_run      = 1'b1;
                low_power_rc_osc_keep_on = 1'b1;
            end
            `CFD_WDT_SOFT:
            begin
                wdt_run      = soft_watchdog_on_bit;
                low_power_rc_osc_keep_on = soft_watchdog_on_bit;
            end
            `CFD_WDT_ACTIVE:
            begin
                wdt_run      = ~sleep_mode;
                low_power_rc_osc_keep_on = ~sleep_mode;
            end
            default:
            begin
                wdt_run      = 1'b0;
                low_power_rc_osc_keep_on = 1'b0;
            end
        endcase
    end
endmodule

// ### rtl/cfd_osc_decode.v
// Primary oscillator mode decode into one-hot selects
`timescale 1ns/100ps
module cfd_osc_decode
(
    // Mode field
    input  wire [1:0] primary_osc_mode_field,
    // Oscillator enable and mutually exclusive mode selects
    output reg        posc_enable,
    output reg        fast_crystal_mode,
    output reg        standard_crystal_mode,
    output reg        driven_clock_input_mode
);
`include "cfd_map.vh"

    always @*
    begin
        posc_enable             = 1'b1;
        fast_crystal_mode       = 1'b0;
        standard_crystal_mode   = 1'b0;
        driven_clock_input_mode = 1'b0;
        case (primary_osc_mode_field)
            `CFD_POSC_OFF:    posc_enable             = 1'b0;
            `CFD_POSC_FAST:   fast_crystal_mode       = 1'b1;
            `CFD_POSC_STD:    standard_crystal_mode   = 1'b1;
            default:          driven_clock_input_mode = 1'b1;
        endcase
    end
endmodule

// ### tb/cfd_config_decode_props.sv
// Port-level assertions for the configuration decoder
`timescale 1ns/100ps
module cfd_props
(
    // Clock and reset
    input wire        mclk,
    input wire        rst,
    // Table read port
    input wire        tbl_rd,
    input wire [23:0] tbl_data,
    input wire        tbl_valid,
    // Decoded outputs
    input wire        posc_enable,
    input wire        fast_crystal_mode,
    input wire        standard_crystal_mode,
    input wire        driven_clock_input_mode,
    input wire        wdt_run,
    input wire        low_power_rc_osc,
    input wire [7:0]  wdt_pre_ratio,
    input wire [15:0] wdt_post_ratio,
    input wire        wdt_prescale_tick,
    input wire        wdt_timeout
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    rd_answer_a: assert property (tbl_rd |=> tbl_valid)
        else $error("read not answered");
    rd_idle_a: assert property (!tbl_rd |=> !tbl_valid)
        else $error("valid without read");
    data_hold_a: assert property (!tbl_rd |=> $stable(tbl_data))
        else $error("read data changed without read");
    osc_onehot_a: assert property ($onehot0({fast_crystal_mode, standard_crystal_mode,
        driven_clock_input_mode}) && posc_enable == (fast_crystal_mode
        | standard_crystal_mode | driven_clock_input_mode))
        else $error("oscillator selects inconsistent");
    rc_for_run_a: assert property (wdt_run |-> low_power_rc_osc)
        else $error("watchdog runs without its oscillator");
    tick_run_a: assert property (!wdt_run |=> !wdt_prescale_tick)
        else $error("tick while stopped");
    tick_gap_a: assert property (wdt_prescale_tick |=> (!wdt_prescale_tick)[*8])
        else $error("prescale ticks too close");
    tout_tick_a: assert property (wdt_timeout |-> wdt_prescale_tick)
        else $error("timeout off a tick");
    ratio_legal_a: assert property (!$past(rst) |-> (wdt_pre_ratio == 8'h80
        || wdt_pre_ratio == 8'h20) && $onehot(wdt_post_ratio))
        else $error("illegal divider ratio");
    cover property (wdt_timeout);
    cover property (tbl_valid);
    cover property (fast_crystal_mode && !wdt_run);
endmodule

// ### tb/tb_top.sv
// Self-checking bench for the configuration decoder
`timescale 1ns/100ps
module tb_top;
    reg         mclk, rst, load_strobe, soft_watchdog_on_bit, sleep_mode, tbl_rd;
    reg  [10:0] cfg_word, c;
    reg  [4:0]  pga1_trim_nv, pga2_trim_nv, p1, p2;
    reg  [5:0]  isrc_trim_nv, is;
    reg  [7:0]  table_page_pointer;
    reg  [15:0] tbl_offset;
    wire [23:0] tbl_data;
    wire [7:0]  wdt_pre_ratio;
    wire [15:0] wdt_post_ratio;
    wire        tbl_valid, posc_enable, fast_crystal_mode, standard_crystal_mode;
    wire        driven_clock_input_mode, pll_lock_enable, wdt_run, low_power_rc_osc;
    wire        wdt_window_mode, wdt_prescale_tick, wdt_timeout;
    integer     n_mismatch, n_tests, i, j, n;
    // Arbitrary identification values
    cfd_config_decode #(.PART_ID_VALUE(16'h1234), .SILICON_REV(16'h0007)) u_dut
    (
        .mclk(mclk), .rst(rst), .load_strobe(load_strobe), .cfg_word(cfg_word),
        .pga1_trim_nv(pga1_trim_nv), .pga2_trim_nv(pga2_trim_nv),
        .isrc_trim_nv(isrc_trim_nv), .soft_watchdog_on_bit(soft_watchdog_on_bit),
        .sleep_mode(sleep_mode), .tbl_rd(tbl_rd), .table_page_pointer(table_page_pointer),
        .tbl_offset(tbl_offset), .tbl_data(tbl_data), .tbl_valid(tbl_valid),
        .posc_enable(posc_enable), .fast_crystal_mode(fast_crystal_mode),
        .standard_crystal_mode(standard_crystal_mode),
        .driven_clock_input_mode(driven_clock_input_mode),
        .pll_lock_enable(pll_lock_enable), .wdt_run(wdt_run),
        .low_power_rc_osc(low_power_rc_osc), .wdt_window_mode(wdt_window_mode),
        .wdt_pre_ratio(wdt_pre_ratio), .wdt_post_ratio(wdt_post_ratio),
        .wdt_prescale_tick(wdt_prescale_tick), .wdt_timeout(wdt_timeout)
    );
    task chk(input string name, input [23:0] exp, input [23:0] got);
        n_tests = n_tests + 1;
        if (got !== exp)
        begin
            n_mismatch = n_mismatch + 1;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task complete_run;
        if (n_mismatch == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task step;
        @(posedge mclk);
        #2;
    endtask
    task do_reset(input integer k);
        rst = 1'b1;
        repeat (k) step;
        rst = 1'b0;
    endtask
    task load(input [10:0] v);
        // The word has no alternate vector select, so no boot segment is needed
        cfg_word = v;
        load_strobe = 1'b1;
        step;
        load_strobe = 1'b0;
        step;
        step;
    endtask
    task rd(input [23:0] a, input [23:0] exp);
        tbl_rd = 1'b1;
        {table_page_pointer, tbl_offset} = a;
        step;
        // Request stays high between back-to-back reads; the caller lowers it
        chk("tbl_valid", 24'h00_0001, {23'h0, tbl_valid});
        chk("tbl_data", exp, tbl_data);
    endtask
    function exp_run(input [1:0] p, input s, input z);
        exp_run = (p == 2'h3) | ((p == 2'h2) & s) | ((p == 2'h1) & ~z);
    endfunction
    function [3:0] exp_osc(input [1:0] m);
        exp_osc = {m != 2'h3, m == 2'h2, m == 2'h1, m == 2'h0};
    endfunction
    function [23:0] exp_ratio(input [10:0] v);
        exp_ratio = {v[6] ? 8'h80 : 8'h20, 16'h0001 << v[10:7]};
    endfunction
    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    initial
    begin
        #250000;
        n_mismatch = n_mismatch + 1;
        complete_run;
    end
    initial
    begin
        {rst, load_strobe, soft_watchdog_on_bit, sleep_mode, tbl_rd} = 5'h10;
        {cfg_word, pga1_trim_nv, pga2_trim_nv, isrc_trim_nv} = 27'h000_0000;
        {table_page_pointer, tbl_offset} = 24'h00_0000;
        n_mismatch = 0;
        n_tests = 0;
        c = $urandom(32'h0000_6d33);
        do_reset(16);
        chk("posc_enable", 24'h00_0000, {23'h0, posc_enable});
        for (i = 0; i < 8; i = i + 1)
        begin
            do_reset(2);
            c = $urandom;
            c[3:0] = {i[2:1], i[1:0]};
            if (i < 3)
                c[10:7] = (i == 0) ? 4'hf : (i == 1) ? 4'he : 4'h0;
            {p1, p2, is} = $urandom;
            {pga1_trim_nv, pga2_trim_nv, isrc_trim_nv} = {p1, p2, is};
            load(c);
            {pga1_trim_nv, pga2_trim_nv, isrc_trim_nv} = $urandom;
            load(~c);
            chk("osc", {20'h0, exp_osc(c[1:0])}, {20'h0, posc_enable, fast_crystal_mode,
                standard_crystal_mode, driven_clock_input_mode});
            chk("pll_lock_enable", {23'h0, c[5]}, {23'h0, pll_lock_enable});
            chk("wdt_window_mode", {23'h0, ~c[4]}, {23'h0, wdt_window_mode});
            chk("ratio", exp_ratio(c), {wdt_pre_ratio, wdt_post_ratio});
            for (j = 0; j < 4; j = j + 1)
            begin
                {sleep_mode, soft_watchdog_on_bit} = j[1:0];
                #1;
                chk("wdt_run", {23'h0, exp_run(c[3:2], j[0], j[1])}, {23'h0, wdt_run});
                chk("low_power_rc_osc", {23'h0, exp_run(c[3:2], j[0], j[1])},
                    {23'h0, low_power_rc_osc});
                step;
            end
            rd(24'h80_0e48, {19'h0, p1});
            rd(24'h80_0e4c, {19'h0, p2});
            rd(24'h80_0e78, {18'h0, is});
            rd(24'hff_0000, 24'h00_1234);
            rd(24'hff_0002, 24'h00_0007);
            rd(24'h80_0e50, 24'h00_0000);
            tbl_rd = 1'b0;
            step;
            chk("tbl_valid idle", 24'h00_0000, {23'h0, tbl_valid});
        end
        do_reset(2);
        load(11'h00c);
        n = 0;
        while (wdt_timeout !== 1'b1 && n < 200)
        begin
            step;
            n = n + 1;
        end
        step;
        n = 1;
        while (wdt_timeout !== 1'b1 && n < 200)
        begin
            step;
            n = n + 1;
        end
        chk("timeout period", 24'd32, n[23:0]);
        complete_run;
    end
endmodule
bind cfd_config_decode cfd_props u_props
(
    .mclk(mclk), .rst(rst), .tbl_rd(tbl_rd), .tbl_data(tbl_data), .tbl_valid(tbl_valid),
    .posc_enable(posc_enable), .fast_crystal_mode(fast_crystal_mode),
    .standard_crystal_mode(standard_crystal_mode),
    .driven_clock_input_mode(driven_clock_input_mode), .wdt_run(wdt_run),
    .low_power_rc_osc(low_power_rc_osc), .wdt_pre_ratio(wdt_pre_ratio),
    .wdt_post_ratio(wdt_post_ratio), .wdt_prescale_tick(wdt_prescale_tick),
    .wdt_timeout(wdt_timeout)
);
